// [hw/tas_seq.sv]
/*
  Triggered acquisition sequencer: arm, ready, trigger, start delay,
  capture, stop delay. Assumes an Avalon-MM master and sample codes on
  the same clock; the trigger pin is asynchronous.
*/
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - acquisition needs a software arm; buffered mode records nothing before a trigger
// R2 - ready rises after a programmable arming latency of 50 us to 10 ms
// R3 - ready falls when the trigger pulse arrives
// R4 - ready stays low while acquiring or when not enabled
// R5 - trigger accepted any time after ready, no timeout on this path; the code leaves ready on a timeout when tmo_en is set
// R6 - trigger gives a trigger output pulse, then start delay, then acquisition
// R7 - trigger output edge is launched by a sample-clock flip-flop
// R8 - trigger output follows the trigger input within a fixed latency, one clock uncertain
// R9 - sampling starts an exact programmed interval after the trigger output
// R10 - length steps of 32 single or 16 dual points, default maxima 4M and 2M
// R11 - optional memory raises length maxima to 16M single and 8M dual
// R12 - start delay maximum 16M points, 32M on the wide single variant
// R13 - zero start delay leaves only an inherent, rate-dependent delay
// R14 - zero start delay forces the first 10 or 5 samples to minimum code
// R15 - programmable stop delay, same range and step, before rearming
// R16 - software sets stop delay zero for the highest rate
// R17 - the outside system fires its event from ready and returns a trigger
// R18 - trigger timeout makes an all-minimum-code acquisition of normal duration
// R19 - delays count sample cycles in the same step as the length
module tas_seq
  import tas_pkg::*;
#(
  parameter bit OPT_MEM = 1'b0,
  parameter bit WIDE_START = 1'b0,
  parameter logic [25:0] ARM_LAT_MAX = 26'(ARM_LAT_MAX_CYC)
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trig_in_pin,
  input wire logic [7:0] adc_code,
  output logic acq_ready_out,
  output logic trig_out,
  output logic acq_done,
  output tas_smp_t smp_out
);
  tas_cfg_t cfg_ff;
  tas_state_t state_ff;
  tas_state_t nxt_state;
  tas_smp_t smp_ff;
  logic arm_pend_ff;
  logic [20:0] len_units_ff, post_trigger_start_delay_ff, rearm_hold_delay_ff, tmo_units_ff;
  logic [25:0] arm_lat_ff, smp_idx_ff, len_q_ff;
  logic zero_q_ff;
  logic art_ff;
  logic nxt_art;
  logic acq_ready_ff;
  logic trig_out_ff;
  logic acq_done_ff;
  logic [31:0] avs_readdata_ff;
  logic avs_waitrequest_ff;
  logic [31:0] rd_mux;
  logic wr_take, trig_rise, trig_take, arm_take, cnt_load, cnt_done, cap_last;
  logic [25:0] cnt_val, gran, len_pts, start_pts, stop_pts, tmo_pts, arm_pts;
  logic [25:0] len_max, dly_max, zero_pts;

  function automatic logic [25:0] tas_to_pts(input logic [20:0] units, input logic dual);
    return dual ? {1'b0, units, 4'h0} : {units, 5'h00};
  endfunction : tas_to_pts

  function automatic logic [25:0] tas_clamp(input logic [25:0] v, input logic [25:0] lo,
                                            input logic [25:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : tas_clamp

  tas_trig_sync tas_trig_sync_i (
    .clock(clock),
    .rst_b(rst_b),
    .pin(trig_in_pin),
    .rise(trig_rise)
  );

  tas_down_cnt #(.W(26)) tas_down_cnt_i (
    .clock(clock),
    .rst_b(rst_b),
    .load(cnt_load),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  // derived point counts, all in sample cycles
  always_comb begin
    gran = cfg_ff.dual ? GRAN_DUAL : GRAN_SGL; // see R19
    zero_pts = cfg_ff.dual ? ZERO_PTS_DUAL : ZERO_PTS_SGL;
    if (OPT_MEM) begin
      len_max = cfg_ff.dual ? LEN_MAX_DUAL_OPT : LEN_MAX_SGL_OPT; // see R11
    end else begin
      len_max = cfg_ff.dual ? LEN_MAX_DUAL_DEF : LEN_MAX_SGL_DEF; // see R10
    end
    dly_max = (WIDE_START && !cfg_ff.dual) ? DLY_MAX_WIDE : DLY_MAX_STD; // see R12
    len_pts = tas_clamp(tas_to_pts(len_units_ff, cfg_ff.dual), gran, len_max); // see R10
    start_pts = tas_clamp(tas_to_pts(post_trigger_start_delay_ff, cfg_ff.dual), '0, dly_max);
    stop_pts = tas_clamp(tas_to_pts(rearm_hold_delay_ff, cfg_ff.dual), '0, dly_max); // see R15
    tmo_pts = tas_clamp(tas_to_pts(tmo_units_ff, cfg_ff.dual), '0, dly_max);
    arm_pts = tas_clamp(arm_lat_ff, 26'(ARM_LAT_MIN_CYC), ARM_LAT_MAX); // see R2
  end

  assign trig_take = (state_ff == TAS_READY) && cfg_ff.enable && trig_rise; // see R5
  assign cap_last = (state_ff == TAS_CAPTURE) && (smp_idx_ff == len_q_ff - 26'h0000001);

  always_comb begin
    nxt_state = state_ff;
    nxt_art = art_ff;
    cnt_load = 1'b0;
    cnt_val = '0;
    arm_take = 1'b0;
    case (state_ff)
      TAS_IDLE: begin
        if (cfg_ff.enable && arm_pend_ff) begin // see R1
          arm_take = 1'b1;
          cnt_load = 1'b1;
          cnt_val = arm_pts;
          nxt_art = 1'b0;
          nxt_state = TAS_ARMING;
        end
      end
      TAS_ARMING: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          if (cfg_ff.buffered) begin
            cnt_val = tmo_pts;
            nxt_state = TAS_READY; // see R2
          end else begin
            cnt_val = start_pts;
            nxt_state = TAS_START_DLY;
          end
        end
      end
      TAS_READY: begin
        if (trig_take) begin
          cnt_load = 1'b1;
          cnt_val = start_pts; // see R6
          nxt_state = TAS_START_DLY;
        end else if (cfg_ff.tmo_en && cnt_done) begin
          cnt_load = 1'b1;
          cnt_val = start_pts; // see R18
          nxt_art = 1'b1;
          nxt_state = TAS_START_DLY;
        end
      end
      TAS_START_DLY: begin
        if (cnt_done) begin
          nxt_state = TAS_CAPTURE; // see R9 see R13
        end
      end
      TAS_CAPTURE: begin
        if (cap_last) begin
          cnt_load = 1'b1;
          cnt_val = stop_pts; // see R15
          nxt_state = TAS_STOP_DLY;
        end
      end
      TAS_STOP_DLY: begin
        if (cnt_done) begin
          nxt_state = TAS_IDLE;
        end
      end
      default: begin
        nxt_state = TAS_IDLE;
      end
    endcase
    // disabling aborts any phase
    if (!cfg_ff.enable) begin
      nxt_state = TAS_IDLE; // see R4
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= TAS_IDLE;
      art_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      art_ff <= nxt_art;
    end
  end

  // ready, trigger out and done are registered pulses or levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acq_ready_ff <= 1'b0;
      trig_out_ff <= 1'b0;
      acq_done_ff <= 1'b0;
    end else begin
      acq_ready_ff <= (nxt_state == TAS_READY); // see R3
      trig_out_ff <= trig_take; // see R7 see R8
      acq_done_ff <= cap_last;
    end
  end

  // length and zero-delay flag freeze during capture
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      smp_idx_ff <= '0;
      len_q_ff <= GRAN_SGL;
      zero_q_ff <= 1'b0;
    end else begin
      smp_idx_ff <= (state_ff == TAS_CAPTURE) ? smp_idx_ff + 26'h0000001 : '0;
      if (state_ff != TAS_CAPTURE) begin
        len_q_ff <= len_pts;
        zero_q_ff <= (start_pts == '0);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      smp_ff <= '0;
    end else begin
      smp_ff.valid <= (state_ff == TAS_CAPTURE); // see R1
      smp_ff.forced <= art_ff || (zero_q_ff && smp_idx_ff < zero_pts);
      if (art_ff || (zero_q_ff && smp_idx_ff < zero_pts)) begin
        smp_ff.code <= MIN_CODE; // see R14
      end else begin
        smp_ff.code <= adc_code;
      end
    end
  end

  // bus slave: one wait cycle, then the request completes
  assign wr_take = avs_write && !avs_waitrequest_ff;

  always_comb begin
    if (avs_address == REG_CTRL) begin
      rd_mux = {27'h0, cfg_ff, 1'b0};
    end else if (avs_address == REG_STATUS) begin
      rd_mux = {24'h0, art_ff, acq_ready_ff, arm_pend_ff, 2'b00, state_ff};
    end else if (avs_address == REG_LEN) begin
      rd_mux = {11'h0, len_units_ff};
    end else if (avs_address == REG_START) begin
      rd_mux = {11'h0, post_trigger_start_delay_ff};
    end else if (avs_address == REG_STOP) begin
      rd_mux = {11'h0, rearm_hold_delay_ff};
    end else if (avs_address == REG_TMO) begin
      rd_mux = {11'h0, tmo_units_ff};
    end else if (avs_address == REG_ARMLAT) begin
      rd_mux = {6'h0, arm_lat_ff};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= 32'h00000000;
    end else begin
      avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
      if (avs_read && avs_waitrequest_ff) begin
        avs_readdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '0;
      len_units_ff <= LEN_RST;
      post_trigger_start_delay_ff <= DLY_RST;
      rearm_hold_delay_ff <= DLY_RST;
      tmo_units_ff <= DLY_RST;
      arm_lat_ff <= ARMLAT_RST;
    end else if (wr_take) begin
      if (avs_address == REG_CTRL) begin
        cfg_ff.enable <= avs_writedata[CTRL_EN_BIT];
        cfg_ff.buffered <= avs_writedata[CTRL_BUF_BIT];
        cfg_ff.dual <= avs_writedata[CTRL_DUAL_BIT];
        cfg_ff.tmo_en <= avs_writedata[CTRL_TMO_BIT];
      end else if (avs_address == REG_LEN) begin
        len_units_ff <= avs_writedata[20:0];
      end else if (avs_address == REG_START) begin
        post_trigger_start_delay_ff <= avs_writedata[20:0];
      end else if (avs_address == REG_STOP) begin
        rearm_hold_delay_ff <= avs_writedata[20:0];
      end else if (avs_address == REG_TMO) begin
        tmo_units_ff <= avs_writedata[20:0];
      end else if (avs_address == REG_ARMLAT) begin
        arm_lat_ff <= avs_writedata[25:0];
      end
    end
  end

  // arm request: a new arm write beats the clear of the one taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arm_pend_ff <= 1'b0;
    end else if (wr_take && avs_address == REG_CTRL && avs_writedata[CTRL_ARM_BIT]) begin
      arm_pend_ff <= 1'b1; // see R1
    end else if (arm_take) begin
      arm_pend_ff <= 1'b0;
    end
  end

  assign avs_readdata = avs_readdata_ff;
  assign avs_waitrequest = avs_waitrequest_ff;
  assign acq_ready_out = acq_ready_ff;
  assign trig_out = trig_out_ff;
  assign acq_done = acq_done_ff;
  assign smp_out = smp_ff;

  // helper counters for the checks below
  logic [25:0] arm_cyc_ff, dly_cyc_ff, vcnt_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arm_cyc_ff <= '0;
      dly_cyc_ff <= '0;
      vcnt_ff <= '0;
    end else begin
      arm_cyc_ff <= (state_ff == TAS_ARMING) ? arm_cyc_ff + 26'h0000001 : '0;
      dly_cyc_ff <= (state_ff == TAS_START_DLY) ? dly_cyc_ff + 26'h0000001 : '0;
      vcnt_ff <= smp_ff.valid ? vcnt_ff + 26'h0000001 : '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_ready_needs_arm: assert property ($rose(acq_ready_out) |-> $past(state_ff) == TAS_ARMING) // see R1
    else $error("ready rose without arming");
  a_arm_lat_range: assert property ($rose(acq_ready_out) |->
      arm_cyc_ff > 26'(ARM_LAT_MIN_CYC) && arm_cyc_ff <= ARM_LAT_MAX + 26'h0000001) // see R2
    else $error("arming latency out of range");
  a_ready_drops_trig: assert property (trig_take |=> !acq_ready_out && trig_out) // see R3
    else $error("ready not dropped on trigger");
  a_ready_low_off: assert property ((!cfg_ff.enable || state_ff == TAS_CAPTURE) |=>
      !acq_ready_out) // see R4
    else $error("ready high while busy or disabled");
  a_ready_waits_trig: assert property ((state_ff == TAS_READY && cfg_ff.enable
      && !cfg_ff.tmo_en && !trig_rise) |=> state_ff == TAS_READY) // see R5
    else $error("ready left without trigger");
  a_trig_out_pulse: assert property (trig_out |-> $past(trig_rise)
      && state_ff == TAS_START_DLY ##1 !trig_out) // see R6
    else $error("trigger output not a single pulse");
  a_start_dly_exact: assert property ((state_ff == TAS_CAPTURE && $past(state_ff) ==
      TAS_START_DLY) |-> dly_cyc_ff == start_pts + 26'h0000001) // see R9
    else $error("start delay mismatch");
  a_len_exact: assert property ($fell(smp_ff.valid) && $past(acq_done) |->
      vcnt_ff == $past(len_q_ff, 2)) // see R10
    else $error("record length mismatch");
  a_zero_force: assert property ((smp_ff.valid && $past(zero_q_ff) && vcnt_ff == '0) |->
      smp_ff.code == MIN_CODE) // see R14
    else $error("zero point not forced");
  a_art_code: assert property ((smp_ff.valid && $past(art_ff)) |->
      smp_ff.forced && smp_ff.code == MIN_CODE) // see R18
    else $error("artificial sample not minimum code");

  c_trig_taken: cover property (trig_take ##1 trig_out);
  c_timeout_art: cover property (state_ff == TAS_READY ##1 state_ff == TAS_START_DLY && art_ff);
  c_stop_done: cover property (state_ff == TAS_STOP_DLY ##1 state_ff == TAS_IDLE);
endmodule : tas_seq
`default_nettype wire

// [hw/tas_pkg.sv]
/*
  Shared constants and types of the triggered acquisition sequencer.
  Assumes a 40 MHz sample-domain clock and a byte-addressed register slave.
*/
package tas_pkg;
  // clock and arming latency
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ARM_LAT_MIN_NS = 50000;
  localparam int unsigned ARM_LAT_MAX_NS = 10000000;
  localparam int unsigned ARM_LAT_MIN_CYC = (ARM_LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARM_LAT_MAX_CYC = ARM_LAT_MAX_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_LEN = 5'h08;
  localparam logic [4:0] REG_START = 5'h0c;
  localparam logic [4:0] REG_STOP = 5'h10;
  localparam logic [4:0] REG_TMO = 5'h14;
  localparam logic [4:0] REG_ARMLAT = 5'h18;

  // control field positions
  localparam int unsigned CTRL_ARM_BIT = 0;
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam int unsigned CTRL_BUF_BIT = 2;
  localparam int unsigned CTRL_DUAL_BIT = 3;
  localparam int unsigned CTRL_TMO_BIT = 4;

  // reset values
  localparam logic [20:0] LEN_RST = 21'h000001;
  localparam logic [20:0] DLY_RST = 21'h000000;
  localparam logic [25:0] ARMLAT_RST = 26'(ARM_LAT_MIN_CYC);

  // granularity, zero points, range limits (points = sample cycles)
  localparam logic [25:0] GRAN_SGL = 26'h0000020;
  localparam logic [25:0] GRAN_DUAL = 26'h0000010;
  localparam logic [25:0] ZERO_PTS_SGL = 26'h000000a;
  localparam logic [25:0] ZERO_PTS_DUAL = 26'h0000005;
  localparam logic [25:0] LEN_MAX_SGL_DEF = 26'h0400000;
  localparam logic [25:0] LEN_MAX_DUAL_DEF = 26'h0200000;
  localparam logic [25:0] LEN_MAX_SGL_OPT = 26'h1000000;
  localparam logic [25:0] LEN_MAX_DUAL_OPT = 26'h0800000;
  localparam logic [25:0] DLY_MAX_STD = 26'h1000000;
  localparam logic [25:0] DLY_MAX_WIDE = 26'h2000000;
  localparam logic [7:0] MIN_CODE = 8'h80;

  typedef enum logic [2:0] {
    TAS_IDLE, TAS_ARMING, TAS_READY, TAS_START_DLY, TAS_CAPTURE, TAS_STOP_DLY
  } tas_state_t;

  typedef struct packed {
    logic tmo_en;
    logic dual;
    logic buffered;
    logic enable;
  } tas_cfg_t;

  typedef struct packed {
    logic valid;
    logic forced;
    logic [7:0] code;
  } tas_smp_t;
endpackage : tas_pkg

// [hw/tas_trig_sync.sv]
/*
  Trigger input resynchroniser with rising-edge pulse.
  Assumes an asynchronous pin; a level counts once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module tas_trig_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pin,
  output logic rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic rise_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // agreed level and its rising edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lvl_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
    end
  end

  assign rise = rise_ff;
endmodule : tas_trig_sync
`default_nettype wire

// [hw/tas_down_cnt.sv]
/*
  Loadable down counter shared by arming, delay and timeout phases.
  done stands while running at zero: a load of N gives done N+1 cycles later.
*/
`timescale 1ns/1ps
`default_nettype none
module tas_down_cnt #(
  parameter int W = 26
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic run_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_ff <= 1'b0;
    end else if (load) begin
      run_ff <= 1'b1;
    end else if (run_ff && cnt_ff == '0) begin
      run_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (run_ff && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign done = run_ff && (cnt_ff == '0);
endmodule : tas_down_cnt
`default_nettype wire

// [tb/tas_evt_src.sv]
/*
  Event source model: fires its event from ready, returns a trigger pulse.
  Assumes the sequencer clock and reset; the pin idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module tas_evt_src (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ready,
  input wire logic fire,
  input wire logic kick,
  input wire logic [15:0] dly,
  output logic trig
);
  logic [16:0] cnt_ff;
  logic rdy_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 17'h0;
      rdy_ff <= 1'b0;
      trig <= 1'b0;
    end else begin
      rdy_ff <= ready;
      // kick ignores ready, to probe refusal outside the ready state
      if ((fire && ready && !rdy_ff) || kick) begin
        cnt_ff <= {1'b0, dly} + 17'h4;
      end else if (cnt_ff != 17'h0) begin
        cnt_ff <= cnt_ff - 17'h1;
      end
      // three cycles high, above the two-cycle minimum
      trig <= (cnt_ff >= 17'h2) && (cnt_ff <= 17'h4);
    end
  end
endmodule : tas_evt_src
`default_nettype wire

// [tb/tas_seq_test.sv]
/*
  Bench for the sequencer: Avalon-MM tasks, a table of acquisitions.
  Assumes tas_pkg and the event source model on the trigger pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tas_seq_test;
  import tas_pkg::*;
  logic clock, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] adc_code, adc_q;
  logic trig_in_pin, acq_ready_out, trig_out, acq_done;
  logic fire, kick, rdy_q, pin_q;
  logic [15:0] fdly;
  tas_smp_t smp_out;
  int num_errors = 0, compares = 0, cyc = 0;
  int arm_c, rdy_c, pin_c, to_c, first_c, done_c, nval, nfor, nto, ndone;
  int t_first[8], t_idle[8];

  tas_seq #(.ARM_LAT_MAX(26'h834)) tas_seq_i (.clock(clock), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_in_pin(trig_in_pin),
    .adc_code(adc_code), .acq_ready_out(acq_ready_out), .trig_out(trig_out),
    .acq_done(acq_done), .smp_out(smp_out));
  tas_evt_src tas_evt_src_i (.clock(clock), .rst_b(rst_b), .ready(acq_ready_out),
    .fire(fire), .kick(kick), .dly(fdly), .trig(trig_in_pin));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // free-running codes so a stale or shifted sample shows
  always @(posedge clock) begin
    adc_code <= adc_code + 8'h1;
  end

  // monitor: edges sample settled values from the previous cycle
  always @(posedge clock) begin
    cyc <= cyc + 1;
    adc_q <= adc_code;
    rdy_q <= acq_ready_out;
    pin_q <= trig_in_pin;
    if (avs_write && !avs_waitrequest && avs_address == REG_CTRL && avs_writedata[0])
      arm_c <= cyc;
    if (acq_ready_out && !rdy_q) rdy_c <= cyc;
    if (trig_in_pin && !pin_q) pin_c <= cyc;
    if (trig_out === 1'b1) begin
      to_c <= cyc;
      nto <= nto + 1;
      chk("ready_at_trig", 0, acq_ready_out);
    end
    if (acq_done === 1'b1) begin
      done_c <= cyc;
      ndone <= ndone + 1;
    end
    if (smp_out.valid === 1'b1) begin
      if (nval == 0) first_c <= cyc;
      nval <= nval + 1;
      chk("ready_in_capture", 0, acq_ready_out);
      if (smp_out.forced === 1'b1) begin
        nfor <= nfor + 1;
        chk("forced_code", MIN_CODE, smp_out.code);
      end else begin
        chk("code", adc_q, smp_out.code);
      end
    end
  end

  task acq(input int r, input logic dual, input logic [20:0] st, input logic [20:0] sp,
           input logic tmo);
    int i;
    nval = 0;
    nfor = 0;
    nto = 0;
    ndone = 0;
    fdly <= (r == 0) ? 16'h12c : 16'h0;
    fire <= !tmo;
    bus_wr(REG_START, {11'h0, st});
    bus_wr(REG_STOP, {11'h0, sp});
    bus_wr(REG_CTRL, {27'h0, tmo, dual, 3'b111});
    i = 0;
    while (ndone == 0 && i < 8000) begin
      @(posedge clock);
      i++;
    end
    i = 0;
    rd = 32'h1;
    while (rd[2:0] != 3'h0 && i < 300) begin
      bus_rd(REG_STATUS, rd);
      i++;
    end
    chk("idle_reached", 0, rd[2:0]);
    t_idle[r] = cyc - done_c;
    t_first[r] = first_c - to_c;
    chk("samples", dual ? 32'h20 : 32'h40, nval);
    chk("done", 1, ndone);
    if (tmo) begin
      chk("artificial_forced", 64, nfor);
      chk("no_trig_out", 0, nto);
    end else begin
      chk("one_trig_out", 1, nto);
      chk("arm_latency", 1, (rdy_c - arm_c) inside {[2001:2004]});
      chk("out_latency", 1, (to_c - pin_c) inside {[4:7]});
      chk("no_early_samples", 1, first_c > to_c);
      chk("zero_points", st == 0 ? (dual ? 5 : 10) : 0, nfor);
    end
    fire <= 1'b0;
  endtask : acq

  initial begin : main
    int i;
    rst_b = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    adc_code = 8'h0;
    fire = 1'b0;
    kick = 1'b0;
    fdly = 16'h0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    bus_rd(REG_LEN, rd);
    chk("len_rst", {11'h0, LEN_RST}, rd);
    bus_rd(REG_START, rd);
    chk("start_rst", 0, rd);
    bus_rd(REG_STOP, rd);
    chk("stop_rst", 0, rd);
    bus_rd(REG_ARMLAT, rd);
    chk("armlat_rst", {6'h0, ARMLAT_RST}, rd);
    bus_rd(5'h1c, rd);
    chk("unmapped", 0, rd);
    chk("ready_idle", 0, acq_ready_out);
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    repeat (20) @(posedge clock);
    chk("trig_ignored_idle", 0, nto);
    bus_wr(REG_LEN, 32'h2);
    bus_wr(REG_TMO, 32'h1);
    acq(0, 1'b0, 21'h1, 21'h0, 1'b0);
    acq(1, 1'b0, 21'h2, 21'h1, 1'b0);
    acq(2, 1'b1, 21'h1, 21'h0, 1'b0);
    acq(3, 1'b1, 21'h2, 21'h0, 1'b0);
    acq(4, 1'b0, 21'h0, 21'h0, 1'b0);
    acq(5, 1'b1, 21'h0, 21'h0, 1'b0);
    acq(6, 1'b0, 21'h1, 21'h0, 1'b1);
    chk("start_step_sgl", 32, t_first[1] - t_first[0]);
    chk("start_step_dual", 16, t_first[3] - t_first[2]);
    chk("stop_step", 1, (t_idle[1] - t_idle[0]) inside {[30:34]});
    chk("start_zero", 2, t_first[4]);
    // non-buffered: capture follows arming with no trigger and no trigger output
    nval = 0;
    nto = 0;
    ndone = 0;
    bus_wr(REG_CTRL, 32'h3);
    i = 0;
    while (ndone == 0 && i < 8000) begin
      @(posedge clock);
      i++;
    end
    chk("direct_done", 1, ndone);
    chk("direct_samples", 32'h40, nval);
    chk("direct_no_trig_out", 0, nto);
    bus_wr(REG_CTRL, 32'h7);
    i = 0;
    while (acq_ready_out !== 1'b1 && i < 3000) begin
      @(posedge clock);
      i++;
    end
    chk("ready_armed", 1, acq_ready_out);
    bus_wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    chk("ready_disabled", 0, acq_ready_out);
    bus_rd(REG_STATUS, rd);
    chk("state_disabled", 0, rd[2:0]);
    end_of_test;
  end

  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    end_of_test;
  end
endmodule : tas_seq_test
`default_nettype wire
